// [design/tlviu_core.sv]
/*
 * Two-level vectored interrupt unit: enable and level registers, per-cycle
 * gating and arbitration, vector call sequencing and in-service tracking.
 * Assumes the CPU reports instruction ends on the same clock, stalls while
 * call_busy is high, and peripherals clear their flags on hw_clear.
 */
// Strobed register access was left to the implementer.
`default_nettype none

module tlviu_core (
    input  wire logic                mclk,
    input  wire logic                nrst,
    input  wire logic                ce,
    input  wire logic [7:0]          addr,
    input  wire logic [7:0]          wdata,
    input  wire logic                we,
    input  wire logic                re,
    output logic      [7:0]          rdata,
    input  wire tlviu_pkg::tlviu_src_s src,
    input  wire tlviu_pkg::tlviu_cpu_s cpu,
    output logic                     call_busy,
    output tlviu_pkg::tlviu_vec_s    vec,
    output logic      [14:0]         hw_clear,
    output logic                     in_service_hi,
    output logic                     in_service_lo
);

    logic [7:0]                enable_reg;
    logic [7:0]                prio_reg;
    logic [7:0]                ext_enable_reg;
    logic [7:0]                ext_prio_reg;
    logic [7:0]                rdata_reg;
    logic [14:0]               flag;
    logic [14:0]               src_en;
    logic [14:0]               src_hi;
    logic [14:0]               gated;
    logic                      win_any;
    logic                      win_hi;
    logic [3:0]                win_idx;
    logic                      req_q;
    logic                      win_hi_q;
    logic [3:0]                win_idx_q;
    tlviu_pkg::tlviu_state_e   state_reg;
    logic [1:0]                cnt_reg;
    logic [3:0]                call_idx_reg;
    logic                      call_hi_reg;
    logic                      call_busy_reg;
    logic                      vec_valid_reg;
    logic [15:0]               vec_addr_reg;
    logic [14:0]               hw_clear_reg;
    logic                      isr_hi_reg;
    logic                      isr_lo_reg;
    logic                      take;
    logic                      vec_fire;

    // Flags are passed through, the two timer 2 flags ORed into source 5; pending state lives in the peripherals
    assign flag = {src.upper_flag,
                   src.timer2_high_overflow_flag | src.timer2_low_overflow_flag,
                   src.lower_flag};
    assign src_en = {ext_enable_reg, enable_reg[6:0]};
    assign src_hi = {ext_prio_reg, prio_reg[6:0]};

    genvar gi;
    generate
        for (gi = 0; gi < tlviu_pkg::NUM_SRC; gi++) begin : g_gate
            assign gated[gi] = flag[gi] & src_en[gi]
                             & enable_reg[tlviu_pkg::GLOBAL_EN_BIT];
        end
    endgenerate

    // Level eligibility against the routine in service, then fixed order
    always_comb begin
        logic hi_ok;
        logic lo_ok;
        hi_ok   = !isr_hi_reg;
        lo_ok   = !isr_hi_reg && !isr_lo_reg;
        win_any = 1'b0;
        win_hi  = 1'b0;
        win_idx = 4'h0;
        for (int i = tlviu_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (gated[i] && !src_hi[i] && lo_ok) begin
                win_any = 1'b1;
                win_idx = 4'(i);
            end
        end
        for (int i = tlviu_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (gated[i] && src_hi[i] && hi_ok) begin
                win_any = 1'b1;
                win_hi  = 1'b1;
                win_idx = 4'(i);
            end
        end
    end

    // Detect stage: one clock per sample
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            req_q     <= 1'b0;
            win_hi_q  <= 1'b0;
            win_idx_q <= 4'h0;
        end else if (ce) begin
            req_q     <= win_any;
            win_hi_q  <= win_hi;
            win_idx_q <= win_idx;
        end
    end

    // A return instruction boundary is refused so one more instruction runs
    assign take = (state_reg == tlviu_pkg::ST_IDLE) && req_q && cpu.instr_end
                && !cpu.irq_return_instr_end;
    assign vec_fire = (state_reg == tlviu_pkg::ST_CALL)
                    && (cnt_reg == 2'(tlviu_pkg::CALL_CYCLES - 2));

    // Vector call sequencer
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg     <= tlviu_pkg::ST_IDLE;
            cnt_reg       <= 2'h0;
            call_idx_reg  <= 4'h0;
            call_hi_reg   <= 1'b0;
            call_busy_reg <= 1'b0;
        end else if (ce) begin
            unique case (state_reg)
                tlviu_pkg::ST_IDLE: begin
                    if (take) begin
                        state_reg     <= tlviu_pkg::ST_CALL;
                        cnt_reg       <= 2'h0;
                        call_idx_reg  <= win_idx_q;
                        call_hi_reg   <= win_hi_q;
                        call_busy_reg <= 1'b1;
                    end
                end
                tlviu_pkg::ST_CALL: begin
                    if (cnt_reg == 2'(tlviu_pkg::CALL_CYCLES - 1)) begin
                        state_reg     <= tlviu_pkg::ST_IDLE;
                        call_busy_reg <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg + 2'h1;
                    end
                end
            endcase
        end
    end

    // Vector issue and hardware flag clears
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            vec_valid_reg <= 1'b0;
            vec_addr_reg  <= tlviu_pkg::RESET_VECTOR;
            hw_clear_reg  <= 15'h0000;
        end else if (ce) begin
            vec_valid_reg <= vec_fire;
            hw_clear_reg  <= 15'h0000;
            if (vec_fire) begin
                vec_addr_reg <= tlviu_pkg::VECTOR_BASE
                              + (tlviu_pkg::VECTOR_STRIDE * {12'h000, call_idx_reg});
                hw_clear_reg <= tlviu_pkg::HW_CLEAR_MASK
                              & (15'h0001 << call_idx_reg);
            end
        end
    end

    // In-service levels; a vector entry outranks a same-cycle return
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            isr_hi_reg <= 1'b0;
            isr_lo_reg <= 1'b0;
        end else if (ce) begin
            if (vec_fire) begin
                if (call_hi_reg) begin
                    isr_hi_reg <= 1'b1;
                end else begin
                    isr_lo_reg <= 1'b1;
                end
            end else if (cpu.irq_return_instr_end && cpu.instr_end) begin
                if (isr_hi_reg) begin
                    isr_hi_reg <= 1'b0;
                end else begin
                    isr_lo_reg <= 1'b0;
                end
            end
        end
    end

    // Register writes
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            enable_reg     <= tlviu_pkg::ENABLE_RESET;
            prio_reg       <= tlviu_pkg::PRIO_RESET;
            ext_enable_reg <= tlviu_pkg::EXT_ENABLE_RESET;
            ext_prio_reg   <= tlviu_pkg::EXT_PRIO_RESET;
        end else if (ce && we) begin
            unique case (addr)
                tlviu_pkg::ENABLE_ADDR:     enable_reg     <= wdata;
                tlviu_pkg::PRIO_ADDR:       prio_reg       <= {1'b1, wdata[6:0]};
                tlviu_pkg::EXT_ENABLE_ADDR: ext_enable_reg <= wdata;
                tlviu_pkg::EXT_PRIO_ADDR:   ext_prio_reg   <= wdata;
                default: begin
                end
            endcase
        end
    end

    // Register reads, data valid the cycle after the strobe only
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= 8'h00;
        end else if (ce) begin
            rdata_reg <= 8'h00;
            if (re) begin
                unique case (addr)
                    tlviu_pkg::ENABLE_ADDR:     rdata_reg <= enable_reg;
                    tlviu_pkg::PRIO_ADDR:       rdata_reg <= {1'b1, prio_reg[6:0]};
                    tlviu_pkg::EXT_ENABLE_ADDR: rdata_reg <= ext_enable_reg;
                    tlviu_pkg::EXT_PRIO_ADDR:   rdata_reg <= ext_prio_reg;
                    tlviu_pkg::STATUS_ADDR:     rdata_reg <= {4'h0, req_q, call_busy_reg,
                                                              isr_hi_reg, isr_lo_reg};
                    default:                    rdata_reg <= tlviu_pkg::UNMAPPED_READ;
                endcase
            end
        end
    end

    assign rdata         = rdata_reg;
    assign call_busy     = call_busy_reg;
    assign vec.valid     = vec_valid_reg;
    assign vec.addr      = vec_addr_reg;
    assign hw_clear      = hw_clear_reg;
    assign in_service_hi = isr_hi_reg;
    assign in_service_lo = isr_lo_reg;

    a_sample_each_cycle: assert property (@(posedge mclk) disable iff (!nrst)
        (ce && (|gated) && !isr_hi_reg && !isr_lo_reg) |=> req_q)
        else $error("enabled request not detected in one clock");

    a_call_four_clocks: assert property (@(posedge mclk) disable iff (!nrst)
        (ce && take) ##1 (ce && call_busy_reg) [*3] |=> (vec_valid_reg && call_busy_reg))
        else $error("vector not issued on fourth call clock");

    a_irq_return_instr_defers_call: assert property (@(posedge mclk) disable iff (!nrst)
        (ce && state_reg == tlviu_pkg::ST_IDLE && cpu.instr_end && cpu.irq_return_instr_end)
        |=> !call_busy_reg)
        else $error("call started at a return boundary");

    a_no_equal_preempt: assert property (@(posedge mclk) disable iff (!nrst)
        (isr_lo_reg && !isr_hi_reg && take) |-> win_hi_q)
        else $error("low request entered over a low routine");

    a_vector_address: assert property (@(posedge mclk) disable iff (!nrst)
        $rose(vec_valid_reg) |-> (vec_addr_reg ==
            16'h0003 + {9'h000, call_idx_reg, 3'b000}))
        else $error("vector address does not match source index");

    a_global_gate_off: assert property (@(posedge mclk) disable iff (!nrst)
        (ce && !enable_reg[tlviu_pkg::GLOBAL_EN_BIT]) |=> !req_q)
        else $error("request detected while globally disabled");

    a_timer2_gate: assert property (@(posedge mclk) disable iff (!nrst)
        (ce && !enable_reg[5]) |=> !(req_q && win_idx_q == 4'h5))
        else $error("timer 2 request passed a cleared enable");

    a_level_bit_fixed: assert property (@(posedge mclk) disable iff (!nrst)
        (ce && re && addr == tlviu_pkg::PRIO_ADDR) |=> rdata[7])
        else $error("level register bit 7 read as zero");

    a_high_not_preempt: assert property (@(posedge mclk) disable iff (!nrst)
        isr_hi_reg |-> !take)
        else $error("high routine was preempted");

    a_high_level_wins: assert property (@(posedge mclk) disable iff (!nrst)
        (ce && (|(gated & src_hi)) && !isr_hi_reg) |=> (req_q && win_hi_q))
        else $error("low level won over a high request");

    a_flag_gate_all: assert property (@(posedge mclk) disable iff (!nrst)
        (ce && !(|gated)) |=> !req_q)
        else $error("request without flag and enables");

endmodule

`default_nettype wire

// [design/tlviu_pkg.sv]
/*
 * Shared constants and types for the two-level vectored interrupt unit:
 * register map, reset values, field positions, vector layout, call timing.
 * Assumes an 8-bit special-register style bus and a single system clock.
 */
`default_nettype none

package tlviu_pkg;

    localparam int NUM_SRC  = 15;
    localparam int IDX_W    = 4;
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 8;
    localparam int VEC_W    = 16;

    // Register offsets
    localparam logic [7:0] ENABLE_ADDR     = 8'hA8;
    localparam logic [7:0] PRIO_ADDR       = 8'hB8;
    localparam logic [7:0] EXT_ENABLE_ADDR = 8'hE6;
    localparam logic [7:0] EXT_PRIO_ADDR   = 8'hF6;
    localparam logic [7:0] STATUS_ADDR     = 8'hEE;

    // Reset values
    localparam logic [7:0] ENABLE_RESET     = 8'h00;
    localparam logic [7:0] PRIO_RESET       = 8'h80;
    localparam logic [7:0] EXT_ENABLE_RESET = 8'h00;
    localparam logic [7:0] EXT_PRIO_RESET   = 8'h00;
    localparam logic [7:0] UNMAPPED_READ    = 8'h00;

    // Field positions
    localparam int GLOBAL_EN_BIT  = 7;
    localparam int PRIO_FIXED_BIT = 7;
    localparam int STAT_ISR_LO    = 0;
    localparam int STAT_ISR_HI    = 1;
    localparam int STAT_CALL      = 2;
    localparam int STAT_REQ       = 3;

    // Sources whose pending flag is cleared by hardware on vectoring
    localparam logic [14:0] HW_CLEAR_MASK = 15'h000F;

    // Vector layout
    localparam logic [15:0] RESET_VECTOR  = 16'h0000;
    localparam logic [15:0] VECTOR_BASE   = 16'h0003;
    localparam logic [15:0] VECTOR_STRIDE = 16'h0008;

    // Timing in system clocks
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES   = 4;
    localparam int CNT_W         = 2;

    typedef enum logic {
        ST_IDLE,
        ST_CALL
    } tlviu_state_e;

    typedef struct packed {
        logic [8:0] upper_flag;
        logic       timer2_high_overflow_flag;
        logic       timer2_low_overflow_flag;
        logic [4:0] lower_flag;
    } tlviu_src_s;

    typedef struct packed {
        logic instr_end;
        logic irq_return_instr_end;
    } tlviu_cpu_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
    } tlviu_vec_s;

endpackage

`default_nettype wire

// [testbench/tlviu_cpu_model.sv]
/* CPU core and interrupt source model for the vectored interrupt unit.
 * Assumes one clock; the bench sets and clears flags and asks for returns. */
`default_nettype none

module tlviu_cpu_model (
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic [15:0]      flag_set,
    input  wire logic [15:0]      flag_clr,
    input  wire logic [3:0]       instr_len,
    input  wire logic             irq_return_instr_req,
    input  wire logic             call_busy,
    input  wire logic [14:0]      hw_clear,
    output tlviu_pkg::tlviu_src_s src,
    output tlviu_pkg::tlviu_cpu_s cpu
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] flag_reg;
    logic [15:0] hw16;
    logic [3:0]  cnt_reg;
    logic        irq_return_instr_reg;
    logic        ie;

    // Source 5 clears both timer 2 flags
    assign hw16 = {hw_clear[14:6], hw_clear[5], hw_clear[5:0]};
    assign src  = flag_reg | flag_set;
    // The CPU stalls during the vector call
    assign ie   = (cnt_reg == 4'h0) && !call_busy;
    assign cpu  = {ie, ie & irq_return_instr_reg};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            flag_reg <= 16'h0000;
        end else begin
            flag_reg <= (flag_reg | flag_set) & ~flag_clr & ~hw16;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 4'h0;
        end else if (ie) begin
            cnt_reg <= instr_len - 4'h1;
        end else if (!call_busy && cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_return_instr_reg <= 1'b0;
        end else begin
            irq_return_instr_reg <= irq_return_instr_req | (irq_return_instr_reg & ~ie);
        end
    end
endmodule

`default_nettype wire

// [testbench/testbench.sv]
/* Self-checking bench for the vectored interrupt unit.
 * Assumes the CPU and source model beside it and a 250 MHz clock. */
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  mclk, nrst, ce, we, re, irq_return_instr_req, call_busy;
    logic                  in_service_hi, in_service_lo, hi;
    logic [7:0]            addr, wdata, rdata, d;
    logic [14:0]           hw_clear, pend, lvl;
    logic [15:0]           flag_set, flag_clr, v;
    logic [3:0]            instr_len;
    tlviu_pkg::tlviu_src_s src;
    tlviu_pkg::tlviu_cpu_s cpu;
    tlviu_pkg::tlviu_vec_s vec;
    int                    err_total, compares, n, w, cyc;

    tlviu_core tlviu_core_i (.mclk(mclk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
        .we(we), .re(re), .rdata(rdata), .src(src), .cpu(cpu), .call_busy(call_busy),
        .vec(vec), .hw_clear(hw_clear), .in_service_hi(in_service_hi),
        .in_service_lo(in_service_lo));
    tlviu_cpu_model tlviu_cpu_model_i (.mclk(mclk), .nrst(nrst), .flag_set(flag_set),
        .flag_clr(flag_clr), .instr_len(instr_len), .irq_return_instr_req(irq_return_instr_req),
        .call_busy(call_busy), .hw_clear(hw_clear), .src(src), .cpu(cpu));

    always #2 mclk = ~mclk;

    function automatic logic [15:0] fbit(int s, logic h);
        if (s < 5) return 16'h0001 << s;
        if (s == 5) return h ? 16'h0040 : 16'h0020;
        return 16'h0001 << (s + 1);
    endfunction

    function automatic int winner(logic [14:0] p, logic [14:0] l);
        for (int s = 0; s < 15; s++) begin
            if (p[s] && l[s]) return s;
        end
        for (int s = 0; s < 15; s++) begin
            if (p[s]) return s;
        end
        return 0;
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        @(posedge mclk);
        addr <= a;
        wdata <= x;
        we <= 1'b1;
        @(posedge mclk);
        we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] x);
        @(posedge mclk);
        addr <= a;
        re <= 1'b1;
        @(posedge mclk);
        re <= 1'b0;
        #1;
        x = rdata;
    endtask

    task automatic fire(input logic [15:0] f);
        @(posedge mclk);
        flag_set <= f;
    endtask

    // Counts edges until a vector pulse; maxc + 1 means none came
    task automatic wait_vec(input int maxc, output int k);
        k = 0;
        do begin
            @(posedge mclk);
            flag_set <= 16'h0000;
            flag_clr <= 16'h0000;
            irq_return_instr_req <= 1'b0;
            #1;
            k++;
        end while (vec.valid !== 1'b1 && k <= maxc);
    endtask

    task automatic svc_end(input logic [15:0] f);
        @(posedge mclk);
        flag_clr <= f;
        @(posedge mclk);
        flag_clr <= 16'h0000;
        irq_return_instr_req <= 1'b1;
    endtask

    task automatic end_sim();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_sim();
        end
    end

    initial begin
        {mclk, nrst, we, re, irq_return_instr_req, addr, wdata, flag_set, flag_clr} = '0;
        ce = 1'b1;
        instr_len = 4'h1;
        void'($urandom(32'h06c74c98));
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        rd(8'hA8, d);
        chk("enable_reset", 16'h0000, 16'(d));
        rd(8'hB8, d);
        chk("level_reset", 16'h0080, 16'(d));
        rd(8'h00, d);
        chk("unmapped", 16'(tlviu_pkg::UNMAPPED_READ), 16'(d));
        wr(8'hB8, 8'h00);
        rd(8'hB8, d);
        chk("level_bit7", 16'h0080, 16'(d));
        wr(8'hB8, 8'h7F);
        rd(8'hB8, d);
        chk("level_rw", 16'h00FF, 16'(d));
        wr(8'hB8, 8'h00);
        // Clock enable low freezes the registers, so this write is lost
        @(posedge mclk);
        ce <= 1'b0;
        wr(8'hA8, 8'h55);
        @(posedge mclk);
        ce <= 1'b1;
        rd(8'hA8, d);
        chk("ce_freeze", 16'h0000, 16'(d));
        // Gating: global off, then own enable off, then both on
        wr(8'hA8, 8'h7F);
        fire(fbit(1, 1'b0));
        wait_vec(20, n);
        chk("global_off", 16'd21, 16'(n));
        wr(8'hA8, 8'h80);
        wait_vec(20, n);
        chk("own_off", 16'd21, 16'(n));
        wr(8'hA8, 8'h82);
        wait_vec(10, n);
        chk("held_vector", 16'h000B, vec.addr);
        svc_end(16'h0000);
        wait_vec(8, n);
        // Best case response
        wr(8'hA8, 8'h81);
        fire(fbit(0, 1'b0));
        wait_vec(10, n);
        chk("best_latency", 16'd5, 16'(n));
        chk("hw_clear0", 16'h0001, 16'(hw_clear));
        svc_end(16'h0000);
        wait_vec(8, n);
        // Every vector, source 5 through both timer 2 flags
        wr(8'hA8, 8'hFF);
        wr(8'hE6, 8'hFF);
        for (int i = 0; i < 16; i++) begin
            w = (i == 15) ? 5 : i;
            fire(fbit(w, i == 15));
            wait_vec(10, n);
            chk("vector", 16'h0003 + 16'(8 * w), vec.addr);
            chk("hw_clear", (w < 4) ? 16'(1 << w) : 16'h0000, 16'(hw_clear));
            svc_end(fbit(w, i == 15));
            wait_vec(8, n);
        end
        // Random simultaneous requests and levels
        for (int r = 0; r < 6; r++) begin
            lvl = 15'($urandom());
            pend = 15'($urandom()) | 15'h0001;
            hi = 1'($urandom());
            wr(8'hB8, {1'b0, lvl[6:0]});
            wr(8'hF6, lvl[14:7]);
            v = 16'h0000;
            for (int s = 0; s < 15; s++) begin
                if (pend[s]) v = v | fbit(s, hi);
            end
            fire(v);
            while (pend != 15'h0000) begin
                w = winner(pend, lvl);
                wait_vec(40, n);
                chk("arbitration", 16'h0003 + 16'(8 * w), vec.addr);
                pend[w] = 1'b0;
                svc_end(fbit(w, 1'b0) | fbit(w, 1'b1));
            end
            wait_vec(12, n);
            chk("no_reentry", 16'd13, 16'(n));
        end
        // Nesting: equal level waits, high preempts low, high not preempted
        wr(8'hF6, 8'h00);
        wr(8'hB8, 8'h02);
        wr(8'hA8, 8'h87);
        fire(fbit(0, 1'b0));
        wait_vec(10, n);
        fire(fbit(2, 1'b0));
        wait_vec(15, n);
        chk("equal_level", 16'd16, 16'(n));
        chk("lo_running", 16'h0001, 16'(in_service_lo));
        rd(8'hEE, d);
        chk("status_lo", 16'h0001, 16'(d));
        fire(fbit(1, 1'b0));
        wait_vec(10, n);
        chk("preempt", 16'h000B, vec.addr);
        @(posedge mclk);
        #1;
        chk("hi_running", 16'h0001, 16'(in_service_hi));
        wr(8'hB8, 8'h06);
        wait_vec(15, n);
        chk("hi_kept", 16'd16, 16'(n));
        svc_end(16'h0000);
        wait_vec(12, n);
        chk("after_hi", 16'h0013, vec.addr);
        svc_end(16'h0000);
        wait_vec(12, n);
        chk("back_to_lo", 16'h0001, 16'(in_service_lo));
        svc_end(16'h0000);
        wait_vec(12, n);
        chk("lo_done", 16'h0000, 16'(in_service_lo));
        chk("hi_done", 16'h0000, 16'(in_service_hi));
        // Flag left set over the return: one more long instruction, then re-entry
        wr(8'hB8, 8'h00);
        wr(8'hA8, 8'h90);
        fire(fbit(4, 1'b0));
        wait_vec(10, n);
        chk("no_hw_clear", 16'h0000, 16'(hw_clear));
        @(posedge mclk);
        instr_len <= 4'h8;
        irq_return_instr_req <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            irq_return_instr_req <= 1'b0;
            #1;
            n++;
        end while (cpu.irq_return_instr_end !== 1'b1 && n < 40);
        wait_vec(30, n);
        chk("irq_return_instr_latency", 16'd12, 16'(n));
        chk("reentry", 16'h0023, vec.addr);
        instr_len <= 4'h1;
        svc_end(fbit(4, 1'b0));
        wait_vec(20, n);
        chk("cleared", 16'd21, 16'(n));
        end_sim();
    end
endmodule

`default_nettype wire
